// *** dv/tb_pit_top.sv ***
`include "pit_params.svh"

module tb_pit_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Small base divider keeps every period short; expectations scale from it
  localparam int unsigned BDIV = 16;

  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        special_mode;
  logic        periodic_irq;
  logic        bypass_active;
  logic [15:0] main_count;
  logic [31:0] rd;
  logic        err;
  logic [15:0] cnt;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          t0;
  int          t1;

  pit_top #(.BASE_DIV(BDIV)) pit_top_i (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .special_mode (special_mode),
    .periodic_irq (periodic_irq),
    .bypass_active(bypass_active),
    .main_count   (main_count)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Request stands until the edge that samples pready high; data taken at that edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // A still-set flag holds the request high, so wait for low first
  task automatic wait_rise();
    int n;
    n = 0;
    while (periodic_irq === 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    while (periodic_irq !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 2000) bad_count++;
    t0 = cyc;
  endtask : wait_rise

  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    special_mode = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `PIT_ADDR_FLAGS, 32'h0);
    chk("flags reset", rd, 32'h0);
    apb(1'b0, `PIT_ADDR_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b0, `PIT_ADDR_ACCCTL, 32'h0);
    chk("rate reset", rd, 32'h0);
    apb(1'b0, `PIT_ADDR_TEST, 32'h0);
    chk("test reset", rd, 32'h0);
    chk("irq after reset", periodic_irq, 32'h0);
    apb(1'b0, 16'h4000, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // Slowest prescale must not change any periodic interval
    apb(1'b1, `PIT_ADDR_MASK, 32'h43);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `PIT_ADDR_ACCCTL, 32'(r));
      apb(1'b0, `PIT_ADDR_ACCCTL, 32'h0);
      chk("rate readback", rd, 32'(r));
      apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
      wait_rise();
      apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
      wait_rise();
      t1 = t0;
      // Late service must not stretch the next period
      repeat (10 * r) @(posedge clk_sys);
      apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
      wait_rise();
      chk("period", 32'(t0 - t1), 32'(BDIV << r));
    end
    apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
    wait_rise();
    apb(1'b1, `PIT_ADDR_MASK, 32'h03);
    repeat (2) @(negedge clk_sys);
    chk("irq masked", periodic_irq, 32'h0);
    apb(1'b0, `PIT_ADDR_FLAGS, 32'h0);
    chk("flag polled", rd, 32'h40);
    apb(1'b1, `PIT_ADDR_FLAGS, 32'hbf);
    apb(1'b0, `PIT_ADDR_FLAGS, 32'h0);
    chk("flag kept", rd, 32'h40);
    apb(1'b0, `PIT_ADDR_MASK, 32'h0);
    chk("mask readback", rd, 32'h03);
    apb(1'b1, `PIT_ADDR_MASK, 32'h43);
    repeat (2) @(negedge clk_sys);
    chk("irq pending", periodic_irq, 32'h1);
    apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
    repeat (2) @(negedge clk_sys);
    chk("irq cleared", periodic_irq, 32'h0);
    apb(1'b0, `PIT_ADDR_FLAGS, 32'h0);
    chk("flag cleared", rd, 32'h0);
    // Clear landing on the timeout edge must leave the flag set
    apb(1'b1, `PIT_ADDR_ACCCTL, 32'h0);
    wait_rise();
    repeat (BDIV - 4) @(posedge clk_sys);
    apb(1'b1, `PIT_ADDR_FLAGS, 32'h40);
    apb(1'b0, `PIT_ADDR_FLAGS, 32'h0);
    chk("set beats clear", rd, 32'h40);
    // Counter bypass only takes effect in special mode
    apb(1'b1, `PIT_ADDR_TEST, 32'h08);
    @(negedge clk_sys);
    chk("bypass refused", bypass_active, 32'h0);
    apb(1'b0, `PIT_ADDR_TEST, 32'h0);
    chk("test ignored", rd, 32'h0);
    special_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, `PIT_ADDR_TEST, 32'h08);
    @(negedge clk_sys);
    chk("bypass on", bypass_active, 32'h1);
    @(negedge clk_sys);
    cnt = main_count;
    @(negedge clk_sys);
    chk("bypass step", main_count, {cnt[15:8] + 8'h01, cnt[7:0] + 8'h01});
    special_mode <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("bypass dropped", bypass_active, 32'h0);
    give_verdict();
  end

endmodule : tb_pit_top

// *** rtl/pit_base_div.sv ***
`include "pit_params.svh"

module pit_base_div #(
  parameter int unsigned DIV = `PIT_BASE_DIV
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Tick out
  output logic      tick
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  // Free running; nothing but reset restarts it
  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 16'h0001;
    if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : pit_base_div

// *** rtl/pit_params.svh ***
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// Register indices; byte address is four times the index
`define PIT_IDX_FLAGS    16'h1025
`define PIT_IDX_MASK     16'h1024
`define PIT_IDX_ACCCTL   16'h1026
`define PIT_IDX_TEST     16'h103e
`define PIT_IDX_COUNT    16'h1040
`define PIT_ADDR_FLAGS   (`PIT_IDX_FLAGS * 16'h0004)
`define PIT_ADDR_MASK    (`PIT_IDX_MASK * 16'h0004)
`define PIT_ADDR_ACCCTL  (`PIT_IDX_ACCCTL * 16'h0004)
`define PIT_ADDR_TEST    (`PIT_IDX_TEST * 16'h0004)
`define PIT_ADDR_COUNT   (`PIT_IDX_COUNT * 16'h0004)

// Field positions
`define PIT_BIT_PERIODIC 6
`define PIT_BIT_SKIP     3
`define PIT_PR_LSB       0
`define PIT_RATE_LSB     0

// Reset values
`define PIT_RST_RATE     2'h0
`define PIT_RST_PR       2'h0

// Base tick: bus clock divided by 2^13
`define PIT_BASE_DIV     8192

// Main counter prescale factors minus one
`define PIT_PRE_1        4'h0
`define PIT_PRE_4        4'h3
`define PIT_PRE_8        4'h7
`define PIT_PRE_16       4'hf

`endif

// *** rtl/pit_pkg.sv ***
package pit_pkg;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pit_apb_req_t;

  typedef enum logic [1:0] {
    PIT_BUS_IDLE = 2'b01,
    PIT_BUS_ACK  = 2'b10
  } pit_bus_st_t;

endpackage : pit_pkg

// *** rtl/pit_rate_div.sv ***
module pit_rate_div (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Base tick and rate
  input  wire logic       tick,
  input  wire logic [1:0] rate,
  // Period end
  output logic            timeout
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] last;

  always_comb begin
    last     = 3'((4'h1 << rate) - 4'h1);
    cnt_next = cnt_reg;
    timeout  = 1'b0;
    if (tick) begin
      // >= so a rate change to a faster setting never stalls a period
      if (cnt_reg >= last) begin
        cnt_next = 3'h0;
        timeout  = 1'b1;
      end else begin
        cnt_next = cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : pit_rate_div

// *** rtl/pit_top.sv ***
`include "pit_params.svh"

module pit_top #(
  parameter int unsigned BASE_DIV = `PIT_BASE_DIV
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Operating mode pin
  input  wire logic        special_mode,
  // Block outputs
  output logic             periodic_irq,
  output logic             bypass_active,
  output logic      [15:0] main_count
);

  pit_pkg::pit_apb_req_t req;

  // One driver for the whole carrier, fields in declaration order
  assign req = {psel, penable, pwrite, paddr, pwdata};

  // Mode pin synchroniser
  logic special_meta_reg;
  logic special_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      special_meta_reg <= 1'b0;
      special_sync_reg <= 1'b0;
    end else begin
      special_meta_reg <= special_mode;
      special_sync_reg <= special_meta_reg;
    end
  end

  // APB answer: one wait state, then pready with registered data
  pit_pkg::pit_bus_st_t st_reg;
  pit_pkg::pit_bus_st_t st_next;
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 pslverr_reg;
  logic                 pslverr_next;
  logic                 mapped;
  logic                 acc;
  logic                 wr_fire;
  logic [31:0]          rd_val;

  logic                 flag_reg;
  logic                 irq_en_reg;
  logic [1:0]           pr_reg;
  logic [1:0]           rate_reg;
  logic                 bypass_reg;
  logic [7:0]           cnt_hi_reg;
  logic [7:0]           cnt_lo_reg;

  assign acc     = req.sel && req.en;
  assign wr_fire = acc && req.wr && (st_reg == pit_pkg::PIT_BUS_ACK);

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (req.addr)
      `PIT_ADDR_FLAGS:  rd_val[`PIT_BIT_PERIODIC] = flag_reg;
      `PIT_ADDR_MASK: begin
        rd_val[`PIT_BIT_PERIODIC]        = irq_en_reg;
        rd_val[`PIT_PR_LSB +: 2]         = pr_reg;
      end
      `PIT_ADDR_ACCCTL: rd_val[`PIT_RATE_LSB +: 2] = rate_reg;
      `PIT_ADDR_TEST:   rd_val[`PIT_BIT_SKIP] = bypass_reg;
      `PIT_ADDR_COUNT:  rd_val[15:0] = {cnt_hi_reg, cnt_lo_reg};
      default:          mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_next      = st_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    case (st_reg)
      pit_pkg::PIT_BUS_IDLE: begin
        if (acc) begin
          st_next      = pit_pkg::PIT_BUS_ACK;
          prdata_next  = req.wr ? 32'h0000_0000 : rd_val;
          pslverr_next = !mapped;
        end
      end
      pit_pkg::PIT_BUS_ACK: begin
        st_next = pit_pkg::PIT_BUS_IDLE;
      end
      default: begin
        st_next = pit_pkg::PIT_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg      <= pit_pkg::PIT_BUS_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = (st_reg == pit_pkg::PIT_BUS_ACK);
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Periodic chain
  logic base_tick;
  logic timeout;

  // Own divider, untouched by the prescale field
  pit_base_div #(
    .DIV (BASE_DIV)
  ) u_base (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (base_tick)
  );

  // No clear input: periods run from timeout to timeout
  pit_rate_div u_rate (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (base_tick),
    .rate    (rate_reg),
    .timeout (timeout)
  );

  // Control and status registers
  logic       flag_next;
  logic       irq_en_next;
  logic [1:0] pr_next;
  logic [1:0] rate_next;
  logic       bypass_next;
  logic       irq_next;
  logic       irq_reg;
  logic       clr_req;

  assign clr_req = wr_fire && (req.addr == `PIT_ADDR_FLAGS) && req.wdata[`PIT_BIT_PERIODIC];

  always_comb begin
    irq_en_next = irq_en_reg;
    pr_next     = pr_reg;
    rate_next   = rate_reg;
    bypass_next = bypass_reg;
    // Set beats clear, enable plays no part
    flag_next   = timeout || (flag_reg && !clr_req);
    if (wr_fire && (req.addr == `PIT_ADDR_MASK)) begin
      irq_en_next = req.wdata[`PIT_BIT_PERIODIC];
      pr_next     = req.wdata[`PIT_PR_LSB +: 2];
    end
    if (wr_fire && (req.addr == `PIT_ADDR_ACCCTL)) begin
      rate_next = req.wdata[`PIT_RATE_LSB +: 2];
    end
    if (wr_fire && (req.addr == `PIT_ADDR_TEST) && special_sync_reg) begin
      bypass_next = req.wdata[`PIT_BIT_SKIP];
    end
    // Bypass gives wrong timing downstream, so it never survives normal mode
    if (!special_sync_reg) begin
      bypass_next = 1'b0;
    end
    irq_next = flag_next && irq_en_next;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_reg   <= 1'b0;
      irq_en_reg <= 1'b0;
      pr_reg     <= `PIT_RST_PR;
      rate_reg   <= `PIT_RST_RATE;
      bypass_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      flag_reg   <= flag_next;
      irq_en_reg <= irq_en_next;
      pr_reg     <= pr_next;
      rate_reg   <= rate_next;
      bypass_reg <= bypass_next;
      irq_reg    <= irq_next;
    end
  end

  assign periodic_irq  = irq_reg;
  assign bypass_active = bypass_reg;

  // Main free-running counter with prescaler
  logic [3:0] pre_reg;
  logic [3:0] pre_next;
  logic [3:0] pre_last;
  logic [7:0] cnt_hi_next;
  logic [7:0] cnt_lo_next;

  always_comb begin
    case (pr_reg)
      2'h0:    pre_last = `PIT_PRE_1;
      2'h1:    pre_last = `PIT_PRE_4;
      2'h2:    pre_last = `PIT_PRE_8;
      default: pre_last = `PIT_PRE_16;
    endcase
    pre_next    = pre_reg;
    cnt_hi_next = cnt_hi_reg;
    cnt_lo_next = cnt_lo_reg;
    if (bypass_reg) begin
      // Halves step independently so a test sees both toggle fast
      pre_next    = 4'h0;
      cnt_hi_next = cnt_hi_reg + 8'h01;
      cnt_lo_next = cnt_lo_reg + 8'h01;
    end else if (pre_reg >= pre_last) begin
      pre_next                   = 4'h0;
      {cnt_hi_next, cnt_lo_next} = {cnt_hi_reg, cnt_lo_reg} + 16'h0001;
    end else begin
      pre_next = pre_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_reg    <= 4'h0;
      cnt_hi_reg <= 8'h00;
      cnt_lo_reg <= 8'h00;
    end else begin
      pre_reg    <= pre_next;
      cnt_hi_reg <= cnt_hi_next;
      cnt_lo_reg <= cnt_lo_next;
    end
  end

  assign main_count = {cnt_hi_reg, cnt_lo_reg};

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence clr_alone_s;
    clr_req && !timeout;
  endsequence

  sequence bus_wait_s;
    psel && penable && !pready;
  endsequence

  flag_set_a: assert property (timeout |=> flag_reg)
    else $error("flag not set after timeout");

  flag_clear_a: assert property (clr_alone_s |=> !flag_reg)
    else $error("flag not cleared by one write");

  set_wins_a: assert property ((timeout && clr_req) |=> flag_reg)
    else $error("timeout lost against clear");

  flag_holds_a: assert property ((flag_reg && !clr_req) |=> flag_reg)
    else $error("flag dropped without a one write");

  irq_follow_a: assert property ((flag_reg && irq_en_reg) |-> periodic_irq)
    else $error("request missing while flag and enable set");

  irq_quiet_a: assert property ((!flag_reg || !irq_en_reg) |-> !periodic_irq)
    else $error("request without flag and enable");

  skip_guard_a: assert property (!special_sync_reg |=> !bypass_active)
    else $error("bypass outside special mode");

  skip_count_a: assert property (bypass_reg |=>
                  (cnt_lo_reg == 8'($past(cnt_lo_reg) + 8'h01)) &&
                  (cnt_hi_reg == 8'($past(cnt_hi_reg) + 8'h01)))
    else $error("halves did not step together");

  fast_rate_a: assert property ((base_tick && rate_reg == 2'h0) |-> timeout)
    else $error("fastest rate missed a tick");

  tick_only_a: assert property (timeout |-> base_tick)
    else $error("timeout without base tick");

  rate_write_a: assert property ((wr_fire && req.addr == `PIT_ADDR_ACCCTL) |=>
                  rate_reg == $past(pwdata[1:0]))
    else $error("rate write ignored");

  bus_answer_a: assert property (bus_wait_s |=> pready)
    else $error("no answer one cycle after access");

endmodule : pit_top
